//--- bench/host_ctrl_model.sv
// Host controller model driving the update strobe and profile pins
`timescale 1ns/1ps
`default_nettype none
module host_ctrl_model (
   // Clocks seen from the device
   input  wire logic       sys_clk_i,
   input  wire logic       sync_clk_i,
   // Pins toward the device
   output var  logic       update_o,
   output var  logic [3:0] profile_o
);
   // Idle pins
   initial begin
      update_o = 1'b0;
      profile_o = 4'h0;
   end
   // Launch just after sync clock falls, far from its sampling rise
   // Needs a running sync clock, or it waits forever
   task automatic strobe(input logic [3:0] pins);
      do @(posedge sys_clk_i); while (sync_clk_i !== 1'b1);
      do @(posedge sys_clk_i); while (sync_clk_i !== 1'b0);
      update_o <= 1'b1;
      profile_o <= pins;
      // Held two sync periods, so a held strobe is sampled twice but must copy once
      repeat (8) @(posedge sys_clk_i);
      update_o <= 1'b0;
      repeat (8) @(posedge sys_clk_i);
   endtask : strobe
endmodule : host_ctrl_model
`default_nettype wire

//--- bench/tb.sv
// Self-checking bench for the control pin block
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        clk, rst_n, hrst, upd, xtal, sen, mst, sin, upl, osc, sclk, sout, stk;
   logic [31:0] bufw, func_one;
   logic [3:0]  pins, prof;
   logic [2:0]  use3;
   int          n_errors = 0, total_checks = 0, n_pulse = 0, cyc = 0;
   pin_ctrl_top pin_ctrl_top_inst (.sys_clk_i(clk), .rst_n_i(rst_n), .hard_reset_i(hrst),
      .buffer_func_one_i(bufw), .update_i(upd), .profile_pins_i(pins), .xtal_sel_i(xtal),
      .sync_clk_en_i(sen), .is_master_i(mst), .sync_in_i(sin),
      .function_reg_one_o(func_one),
      .update_pulse_o(upl), .profile_o(prof), .pin_use_o(use3), .osc_enable_o(osc),
      .sync_clk_o(sclk), .sync_out_o(sout), .sync_taken_o(stk));
   host_ctrl_model host_ctrl_model_inst (.sys_clk_i(clk), .sync_clk_i(sclk),
      .update_o(upd), .profile_o(pins));
   // Clock, 40 ns period
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Transfer pulses counted away from the launching edge
   always @(negedge clk) if (upl === 1'b1) n_pulse++;
   // Hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_errors++;
         final_report();
      end
   end
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   task automatic t_reset;
      cmp(func_one, 32'h0);
      cmp(32'(use3), 32'h1);
      $display("reset done");
   endtask : t_reset
   // Config codes 0 to 3, including one unlisted code; held strobe must copy once only
   task automatic t_update;
      logic [2:0]  ue [4] = '{3'h1, 3'h2, 3'h4, 3'h1};
      logic [31:0] prev, w;
      int          p0;
      prev = 32'h0;
      for (int k = 0; k < 4; k++) begin
         w = 32'hc3c0_0a5c | (32'(k) << 12);
         bufw <= w;
         repeat (6) @(posedge clk);
         cmp(func_one, prev);
         p0 = n_pulse;
         host_ctrl_model_inst.strobe(4'(k + 9));
         cmp(func_one, w);
         cmp(32'(n_pulse - p0), 32'h1);
         cmp(32'(prof), 32'(k + 9));
         cmp(32'(use3), 32'(ue[k]));
         prev = w;
      end
      $display("update done");
   endtask : t_update
   task automatic t_hard;
      hrst <= 1'b1;
      @(posedge clk);
      hrst <= 1'b0;
      repeat (2) @(posedge clk);
      cmp(func_one, 32'h0);
      cmp(32'(use3), 32'h1);
      $display("hard reset done");
   endtask : t_hard
   task automatic t_osc;
      for (int v = 1; v >= 0; v--) begin
         xtal <= 1'(v);
         repeat (2) @(posedge clk);
         cmp(32'(osc), 32'(v));
      end
      $display("oscillator done");
   endtask : t_osc
   task automatic t_sync;
      int   r = 0, o = 0;
      logic ps;
      mst <= 1'b1;
      repeat (2) @(negedge clk);
      ps = sclk;
      repeat (16) begin
         @(negedge clk);
         if (sclk === 1'b1 && ps === 1'b0) r++;
         ps = sclk;
         if (sout === 1'b1) o++;
      end
      cmp(32'(r), 32'h4);
      cmp(32'(o), 32'h4);
      @(posedge clk);
      sen <= 1'b0;
      mst <= 1'b0;
      sin <= 1'b1;
      repeat (3) @(negedge clk);
      cmp(32'(stk), 32'h1);
      r = 0;
      repeat (8) begin
         @(negedge clk);
         if (sclk !== 1'b0 || sout !== 1'b0) r++;
      end
      cmp(32'(r), 32'h0);
      $display("sync done");
   endtask : t_sync
   task automatic final_report;
      $display("checks=%0d mismatches=%0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : final_report
   // Main sequence
   initial begin
      {rst_n, hrst, xtal, mst, sin, bufw} = '0;
      sen = 1'b1;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      t_reset();
      t_update();
      t_hard();
      t_osc();
      t_sync();
      final_report();
   end
endmodule : tb
`default_nettype wire

//--- design/pin_ctrl_pkg.sv
// Constants for the synthesizer control pin block
package pin_ctrl_pkg;
   localparam int          REG_W          = 32;      // Width of function register one
   localparam int          CFG_LSB        = 12;      // Profile config field low bit
   localparam int          CFG_MSB        = 14;      // Profile config field high bit
   localparam logic [31:0] FUNC_ONE_RESET = 32'h0000_0000; // Function register default
   localparam logic [3:0]  PROFILE_RESET  = 4'h0;    // Sampled profile pins default
   localparam logic        UPDATE_IDLE    = 1'b0;    // Update level assumed after reset
   localparam logic        SYNC_IDLE      = 1'b0;    // Sync level after reset
   localparam logic [1:0]  SYNC_DIV_LAST  = 2'h3;    // Divide by four: count 0..3
   localparam logic [1:0]  SYNC_DIV_HALF  = 2'h2;    // Sync clock goes high at this count
   // Profile pin functions selected by the config field
   localparam logic [2:0]  CFG_MOD        = 3'h0;    // Modulation level select
   localparam logic [2:0]  CFG_SWEEP      = 3'h1;    // Sweep start and stop
   localparam logic [2:0]  CFG_RAMP       = 3'h2;    // Amplitude ramp up and down

   // Decoded use of the profile pins
   typedef enum logic [2:0] {
      USE_MOD   = 3'b001,
      USE_SWEEP = 3'b010,
      USE_RAMP  = 3'b100
   } pin_use_t;
endpackage : pin_ctrl_pkg

//--- design/pin_ctrl_top.sv
// Control pin front end: update strobe, profile pins, sync and oscillator
`timescale 1ns/1ps
`default_nettype none
module pin_ctrl_top #(
   parameter int REG_WIDTH = pin_ctrl_pkg::REG_W  // Function register width
) (
   // Clock and resets
   input  wire logic                 sys_clk_i,
   input  wire logic                 rst_n_i,
   input  wire logic                 hard_reset_i,       // Active-high hard reset pin
   // Serial port buffer side
   input  wire logic [REG_WIDTH-1:0] buffer_func_one_i,  // Buffered function register one
   // Control pins
   input  wire logic                 update_i,           // Update strobe
   input  wire logic [3:0]           profile_pins_i,     // Four profile pins
   input  wire logic                 xtal_sel_i,         // Crystal oscillator select
   input  wire logic                 sync_clk_en_i,      // Sync clock output enable
   input  wire logic                 is_master_i,        // This device is sync master
   input  wire logic                 sync_in_i,          // Sync from master
   // Outputs
   output logic [REG_WIDTH-1:0]      function_reg_one_o, // Active register
   output logic                      update_pulse_o,     // One-cycle transfer strobe
   output logic [3:0]                profile_o,          // Sampled profile pins
   output logic [2:0]                pin_use_o,          // One-hot profile function
   output logic                      osc_enable_o,       // Oscillator section enabled
   output logic                      sync_clk_o,         // Divided sync clock
   output logic                      sync_out_o,         // Sync to slaves
   output logic                      sync_taken_o        // Sync used internally
);
   // Elaboration check: field must fit in the register
   if (REG_WIDTH <= pin_ctrl_pkg::CFG_MSB) begin : g_bad_width
      $error("REG_WIDTH too small for profile config field");
   end

   // ------------------------------------------------------------------
   // Internal state
   // ------------------------------------------------------------------

   // Divider outputs, carried through the shared interface
   sync_if                 sync ();
   // Update level seen at the last sync sample
   logic                   update_prev_reg;
   // Rising edge of update seen at a sync sample
   logic                   update_edge;
   // Active copy of function register one
   logic [REG_WIDTH-1:0]   func_one_reg;
   // Profile pins as last sampled
   logic [3:0]             profile_reg;
   // Registered sync level, own phase or from the master
   logic                   sync_reg;
   // Decoded use of the profile pins
   pin_ctrl_pkg::pin_use_t use_reg;
   // Profile config field of the active register
   logic [2:0]             cfg_field;

   // ------------------------------------------------------------------
   // Sync clock divider
   // ------------------------------------------------------------------

   // Divided sync clock generator; hard reset realigns its phase too
   sync_clk_div u_div (
      .sys_clk_i    (sys_clk_i),
      .rst_n_i      (rst_n_i),
      .hard_reset_i (hard_reset_i),
      .sync         (sync.gen)
   );

   // ------------------------------------------------------------------
   // Update strobe
   // ------------------------------------------------------------------

   // Edge detect on sync samples only; sampling per sync clock fixes latency
   // A strobe that rises and falls again between samples is simply not seen
   assign update_edge = sync.sample_en && update_i && !update_prev_reg;

   // Remember update level at each sync sample
   // Idle-low after reset, so a strobe already high still counts as an edge
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i || hard_reset_i) begin
         update_prev_reg <= pin_ctrl_pkg::UPDATE_IDLE;
      end else if (sync.sample_en) begin
         update_prev_reg <= update_i;
      end
   end

   // Active register changes only on an update edge or a reset
   // Buffer writes between edges reach the outputs only at the next edge
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i || hard_reset_i) begin
         func_one_reg <= REG_WIDTH'(pin_ctrl_pkg::FUNC_ONE_RESET);
      end else if (update_edge) begin
         func_one_reg <= buffer_func_one_i;
      end
   end

   // ------------------------------------------------------------------
   // Profile pins
   // ------------------------------------------------------------------

   // Profile pins sampled on the sync clock edge
   // Same sample point as update, so both share one fixed latency
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i || hard_reset_i) begin
         profile_reg <= pin_ctrl_pkg::PROFILE_RESET;
      end else if (sync.sample_en) begin
         profile_reg <= profile_pins_i;
      end
   end

   // Config field taken from the active copy, never from the buffer
   assign cfg_field = func_one_reg[pin_ctrl_pkg::CFG_MSB:pin_ctrl_pkg::CFG_LSB];

   // Decode pin function from the active config field
   // One cycle behind the register, traded for a clean flop output
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i || hard_reset_i) begin
         use_reg <= pin_ctrl_pkg::USE_MOD;
      end else begin
         case (cfg_field)
            pin_ctrl_pkg::CFG_MOD:   use_reg <= pin_ctrl_pkg::USE_MOD;
            pin_ctrl_pkg::CFG_SWEEP: use_reg <= pin_ctrl_pkg::USE_SWEEP;
            pin_ctrl_pkg::CFG_RAMP:  use_reg <= pin_ctrl_pkg::USE_RAMP;
            // Unlisted codes fall back to modulation
            default:                 use_reg <= pin_ctrl_pkg::USE_MOD;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Multi-device sync
   // ------------------------------------------------------------------

   // Sync path: master forwards its sample phase, slave registers input
   // Slave input is taken as synchronous; no second flop is spent on it
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i || hard_reset_i) begin
         sync_reg <= pin_ctrl_pkg::SYNC_IDLE;
      end else begin
         sync_reg <= is_master_i ? sync.sample_en : sync_in_i;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------

   // Data outputs straight from flops
   assign function_reg_one_o = func_one_reg;
   assign profile_o          = profile_reg;
   assign pin_use_o          = use_reg;
   assign sync_taken_o       = sync_reg;
   // Transfer strobe is the unregistered edge detect, so it stays combinational
   assign update_pulse_o     = update_edge;
   // Crystal select passes straight to the oscillator section
   assign osc_enable_o       = xtal_sel_i;
   // Disabled sync clock parks low
   assign sync_clk_o         = sync_clk_en_i && sync.sync_clk;
   // Only a master drives its sync out
   assign sync_out_o         = is_master_i && sync_reg;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------

   // Edge copies the buffer word whole
   update_copy_a : assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (update_edge && !hard_reset_i) |=> (func_one_reg == $past(buffer_func_one_i)))
      else $error("update edge did not copy buffer");

   // A held strobe copies once: no edge for the rest of the sync period
   held_once_a : assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      update_edge |=> !update_edge [*3])
      else $error("update edge repeated within a sync period");

   // Nothing moves the active register but an edge or reset
   hold_buffer_a : assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (!update_edge && !hard_reset_i) |=> $stable(func_one_reg))
      else $error("active register changed without update");

   // Hard reset clears the active state
   hard_reset_a : assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      hard_reset_i |=> (func_one_reg == REG_WIDTH'(pin_ctrl_pkg::FUNC_ONE_RESET))
         && profile_reg == pin_ctrl_pkg::PROFILE_RESET)
      else $error("hard reset left state");

   // Profile pins hold between samples
   profile_sample_a : assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (!sync.sample_en && !hard_reset_i) |=> $stable(profile_reg))
      else $error("profile sampled off sync edge");

   // Profile pins are taken at a sample
   profile_load_a : assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (sync.sample_en && !hard_reset_i) |=> profile_reg == $past(profile_pins_i))
      else $error("profile pins not taken at sample");

   // Sweep code decodes to sweep use
   pin_decode_a : assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (cfg_field == pin_ctrl_pkg::CFG_SWEEP && !hard_reset_i)
         |=> use_reg == pin_ctrl_pkg::USE_SWEEP)
      else $error("sweep config not decoded");

   // Ramp code decodes to ramp use
   ramp_decode_a : assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (cfg_field == pin_ctrl_pkg::CFG_RAMP && !hard_reset_i)
         |=> use_reg == pin_ctrl_pkg::USE_RAMP)
      else $error("ramp config not decoded");

   // A slave keeps its sync out low
   slave_quiet_a : assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      !is_master_i |-> !sync_out_o)
      else $error("slave drove sync out");

   // Oscillator enable follows the select pin
   osc_select_a : assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      osc_enable_o == xtal_sel_i)
      else $error("oscillator select mismatch");
   slave_sync_a : assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (!is_master_i && !hard_reset_i) |=> sync_taken_o == $past(sync_in_i))
      else $error("slave sync not taken");
   clk_gate_a : assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      !sync_clk_en_i |-> !sync_clk_o)
      else $error("sync clock not disabled");
endmodule : pin_ctrl_top
`default_nettype wire

//--- design/sync_clk_div.sv
// Divide-by-four sync clock generator
`timescale 1ns/1ps
`default_nettype none
module sync_clk_div (
   // Clock and reset
   input  wire logic sys_clk_i,
   input  wire logic rst_n_i,
   input  wire logic hard_reset_i,
   // Divided clock out
   sync_if.gen       sync
);
   logic [1:0] div_reg;  // Phase counter

   // Free-running phase counter, realigned by either reset
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i || hard_reset_i) begin
         div_reg <= 2'h0;
      end else if (div_reg == pin_ctrl_pkg::SYNC_DIV_LAST) begin
         div_reg <= 2'h0;
      end else begin
         div_reg <= div_reg + 2'h1;
      end
   end

   // Rising edge of the divided clock is where pins are sampled
   assign sync.sync_clk  = (div_reg >= pin_ctrl_pkg::SYNC_DIV_HALF);
   assign sync.sample_en = (div_reg == pin_ctrl_pkg::SYNC_DIV_HALF);

   quarter_rate_a : assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (sync.sample_en && !hard_reset_i) |=> !sync.sample_en [*3] ##1 (sync.sample_en || $past(hard_reset_i, 1) || hard_reset_i || $past(hard_reset_i, 2) || $past(hard_reset_i, 3)))
      else $error("sync sample not every four cycles");
endmodule : sync_clk_div
`default_nettype wire

//--- design/sync_if.sv
// Interface carrying sync clock phase between the divider and the top
`timescale 1ns/1ps
`default_nettype none
interface sync_if;
   logic sync_clk;   // Divided sync clock level
   logic sample_en;  // One-cycle pulse at sync clock rising edge
   modport gen (output sync_clk, output sample_en);
   modport use_side (input sync_clk, input sample_en);
endinterface : sync_if
`default_nettype wire
